// [common/asrb_map.vh]
// Purpose: Offsets, field positions, reset values and codes of the converter register bank
// Assumes: Included by the bank and the pattern generator
// Notes:   Definitions only
`ifndef ASRB_MAP_VH
`define ASRB_MAP_VH

// Register offsets, 13-bit serial address
`define ASRB_ADDR_PORT_SETUP   13'h0000
`define ASRB_ADDR_PART_ID      13'h0001
`define ASRB_ADDR_SPEED_CLASS  13'h0002
`define ASRB_ADDR_POWER_STATE  13'h0008
`define ASRB_ADDR_STABILIZER   13'h0009
`define ASRB_ADDR_PATTERN_SEL  13'h000d
`define ASRB_ADDR_INPUT_PATH   13'h000f
`define ASRB_ADDR_COMMIT       13'h00ff
`define ASRB_SHADOW_LO         13'h0008
`define ASRB_SHADOW_HI         13'h0018

// Reset values
`define ASRB_RST_PORT_SETUP    8'h18
`define ASRB_RST_POWER_STATE   8'h00
`define ASRB_RST_STABILIZER    8'h01
`define ASRB_RST_PATTERN_SEL   8'h00
`define ASRB_RST_INPUT_PATH    8'h00
`define ASRB_RST_COMMIT        8'h00

// Port setup fields
`define ASRB_PS_LSB_HI         6
`define ASRB_PS_SRST_HI        5
`define ASRB_PS_SRST_LO        2
`define ASRB_PS_LSB_LO         1
`define ASRB_PS_FIXED          8'h18

// Speed class field, bits 4:3
`define ASRB_SC_POS            3

// Power state fields
`define ASRB_PW_PIN_MODE       5
`define ASRB_PW_MODE_MSB       2
`define ASRB_PW_NORMAL         3'h0
`define ASRB_PW_FULL           3'h1
`define ASRB_PW_STANDBY        3'h2
`define ASRB_PW_NORMAL_ALT     3'h3

// Stabilizer field
`define ASRB_DCS_EN            0

// Pattern select fields
`define ASRB_TP_HOLD_LONG      5
`define ASRB_TP_HOLD_SHORT     4
`define ASRB_TP_MODE_MSB       3
`define ASRB_TP_OFF            4'h0
`define ASRB_TP_MIDSCALE       4'h1
`define ASRB_TP_POS_FS         4'h2
`define ASRB_TP_NEG_FS         4'h3
`define ASRB_TP_CHECKER        4'h4
`define ASRB_TP_LONG_PRBS      4'h5
`define ASRB_TP_SHORT_PRBS     4'h6
`define ASRB_TP_WORD_TOGGLE    4'h7

// Input path fields
`define ASRB_IP_DISCONNECT     2
`define ASRB_IP_CM_OUT         1

// Commit field
`define ASRB_CM_BIT            0

// Serial framing
`define ASRB_INSTR_BITS        5'h10
`define ASRB_BYTE_BITS         4'h8
`define ASRB_W_STREAM          2'h3

`endif

// [logic/asrb_pattern.v]
// Purpose: Test pattern source that replaces converter words on the data outputs
// Assumes: conv_data is on the same clock; test_mode comes from the active configuration
// Notes:   Unused test codes pass conversion data through
`timescale 1ns/10ps
`default_nettype none
`include "asrb_map.vh"

module asrb_pattern #(
  parameter DATA_W = 11
) (
  input  wire              clock,
  input  wire              rst,
  input  wire [3:0]        test_mode,
  input  wire              hold_long,
  input  wire              hold_short,
  input  wire [DATA_W-1:0] conv_data,
  output reg  [DATA_W-1:0] data_out,
  output reg               test_active
);

  reg  [22:0]       long_lfsr;
  reg  [8:0]        short_lfsr;
  reg               phase;
  reg  [DATA_W-1:0] next_data;
  reg               next_active;

  // Alternating ones and zeros, twice the word width so no bits are cut
  localparam [2*DATA_W-1:0] CHECK_WORD = {DATA_W{2'b01}};

  // Generators; hold bits keep each in its seed state
  // RULE14: prbs generator hold
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      long_lfsr  <= 23'h7fffff;
      short_lfsr <= 9'h1ff;
      phase      <= 1'b0;
    end else begin
      phase <= ~phase;
      if (hold_long) begin
        long_lfsr <= 23'h7fffff;
      end else begin
        long_lfsr <= {long_lfsr[21:0], long_lfsr[22] ^ long_lfsr[17]};
      end
      if (hold_short) begin
        short_lfsr <= 9'h1ff;
      end else begin
        short_lfsr <= {short_lfsr[7:0], short_lfsr[8] ^ short_lfsr[4]};
      end
    end
  end

  // Pattern choice
  // RULE11: test code decode
  always @* begin
    next_active = 1'b1;
    case (test_mode)
      `ASRB_TP_MIDSCALE:    next_data = {1'b1, {(DATA_W-1){1'b0}}};
      `ASRB_TP_POS_FS:      next_data = {DATA_W{1'b1}};
      `ASRB_TP_NEG_FS:      next_data = {DATA_W{1'b0}};
      `ASRB_TP_CHECKER:     next_data = phase ? ~CHECK_WORD[DATA_W-1:0] : CHECK_WORD[DATA_W-1:0];
      `ASRB_TP_LONG_PRBS:   next_data = long_lfsr[DATA_W-1:0];
      `ASRB_TP_SHORT_PRBS:  next_data = {long_lfsr[DATA_W-1:9], short_lfsr};
      `ASRB_TP_WORD_TOGGLE: next_data = {DATA_W{phase}};
      default: begin
        next_data   = conv_data;
        next_active = 1'b0;
      end
    endcase
  end

  // Output register, pattern in place of conversion data
  // RULE10: pattern replaces data
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      data_out    <= {DATA_W{1'b0}};
      test_active <= 1'b0;
    end else begin
      data_out    <= next_data;
      test_active <= next_active;
    end
  end

endmodule // asrb_pattern
`default_nettype wire

// [logic/asrb_bank.v]
// Purpose: Serial-port register bank with shadowed function registers and commit
// Assumes: Three-wire port sampled by clock; conv_data on clock
// Notes:   Address steps down in MSB-first mode and up in LSB-first mode
//
// Notes on behaviour
// RULE1: writes to 0x08-0x18 go to shadow
// RULE2: writing 0x01 to 0xFF commits
// RULE3: all shadows copy to active together
// RULE4: commit bit clears itself after update
// RULE5: fixed part identifier, writes ignored
// RULE6: speed grade in bits 4:3, read-only
// RULE7: power field selects normal, down, standby
// RULE8: external power-down pin overrides register
// RULE9: bit 0 enables duty-cycle stabilizer
// RULE10: selected pattern replaces conversion data
// RULE11: four-bit code chooses test pattern
// RULE12: bit 2 disconnects analog input
// RULE13: host mirrors port-setup nibbles
// RULE14: bits 5,4 hold PRBS generators reset
// RULE15: 16-bit instruction then counted data bytes
// RULE16: MSB first until setup selects LSB
// RULE17: reset reloads documented defaults
`timescale 1ns/10ps
`default_nettype none
`include "asrb_map.vh"

module asrb_bank #(
  parameter [7:0] PART_ID     = 8'ha5, // Arbitrary value
  parameter [1:0] SPEED_GRADE = 2'h0,
  parameter       DATA_W      = 11
) (
  input  wire              clock,
  input  wire              rst,
  input  wire              csb_n,
  input  wire              sclk,
  input  wire              sdio_in,
  output reg               sdio_out,
  output reg               sdio_oe,
  input  wire              powerdown_pin,
  input  wire [DATA_W-1:0] conv_data,
  output wire [DATA_W-1:0] data_out,
  output wire              test_active,
  output reg               full_powerdown,
  output reg               standby,
  output reg               dcs_enable,
  output reg               input_disconnect,
  output reg               common_mode_out
);

  localparam [1:0] ST_INSTR = 2'h0;
  localparam [1:0] ST_DATA  = 2'h1;
  localparam [1:0] ST_DONE  = 2'h2;

  // Synchronisers and edge history
  reg  [2:0]  sclk_sync;
  reg  [1:0]  csb_sync;
  reg  [1:0]  sdio_sync;
  reg  [1:0]  pin_sync;

  // Serial engine
  reg  [1:0]  state;
  reg  [4:0]  bit_cnt;
  reg  [15:0] shift;
  reg         is_read;
  reg  [1:0]  byte_mode;
  reg  [1:0]  bytes_left;
  reg  [12:0] addr;
  reg  [7:0]  tx_byte;

  // Registers: setup, shadow and active copies, commit
  reg         lsb_first;
  reg         soft_reset;
  reg  [7:0]  sh_power;
  reg  [7:0]  sh_stab;
  reg  [7:0]  sh_pattern;
  reg  [7:0]  sh_input;
  reg  [7:0]  act_power;
  reg  [7:0]  act_stab;
  reg  [7:0]  act_pattern;
  reg  [7:0]  act_input;
  reg         commit_bit;

  wire        sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  wire        sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  wire        frame     = ~csb_sync[1];
  wire        bit_in    = sdio_sync[1];

  // Read value of one address; undefined and unmapped bits read zero
  function [7:0] read_reg;
    input [12:0] a;
    begin
      if (a == `ASRB_ADDR_PORT_SETUP) begin
        read_reg = `ASRB_PS_FIXED | ({7'h0, lsb_first} << `ASRB_PS_LSB_HI)
                 | ({7'h0, lsb_first} << `ASRB_PS_LSB_LO);
      // RULE5: fixed identifier read
      end else if (a == `ASRB_ADDR_PART_ID) begin
        read_reg = PART_ID;
      // RULE6: speed grade read
      end else if (a == `ASRB_ADDR_SPEED_CLASS) begin
        read_reg = {6'h0, SPEED_GRADE} << `ASRB_SC_POS;
      end else if (a == `ASRB_ADDR_POWER_STATE) begin
        read_reg = sh_power;
      end else if (a == `ASRB_ADDR_STABILIZER) begin
        read_reg = sh_stab;
      end else if (a == `ASRB_ADDR_PATTERN_SEL) begin
        read_reg = sh_pattern;
      end else if (a == `ASRB_ADDR_INPUT_PATH) begin
        read_reg = sh_input;
      end else if (a == `ASRB_ADDR_COMMIT) begin
        read_reg = {7'h0, commit_bit};
      end else begin
        read_reg = 8'h00;
      end
    end
  endfunction

  // Next address of a multi-byte access
  function [12:0] step_addr;
    input [12:0] a;
    input        up;
    begin
      step_addr = up ? a + 13'h0001 : a - 13'h0001;
    end
  endfunction

  // Two flip-flops on every pin before use; third sclk stage only for edges
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_sync <= 3'h0;
      csb_sync  <= 2'h3;
      sdio_sync <= 2'h0;
      pin_sync  <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      csb_sync  <= {csb_sync[0], csb_n};
      sdio_sync <= {sdio_sync[0], sdio_in};
      pin_sync  <= {pin_sync[0], powerdown_pin};
    end
  end

  // Incoming shift word in the current bit order
  // RULE16: bit order select
  wire [15:0] next_shift = lsb_first ? {bit_in, shift[15:1]} : {shift[14:0], bit_in};
  wire [7:0]  rx_byte    = lsb_first ? next_shift[15:8] : next_shift[7:0];
  wire        instr_done = (state == ST_INSTR) && sclk_rise && (bit_cnt == `ASRB_INSTR_BITS - 5'h1);
  wire        byte_done  = (state == ST_DATA) && sclk_rise
                         && (bit_cnt == {1'b0, `ASRB_BYTE_BITS} - 5'h1);
  wire        wr_en      = byte_done && !is_read;
  // Either order leaves instruction bit 15 at the top of the shift word
  wire [7:0]  instr_hi   = next_shift[15:8];
  wire [15:0] instr_word = next_shift;
  wire [12:0] instr_addr = instr_word[12:0];

  // Framing: instruction, then data bytes counted by the byte-count field
  // RULE15: instruction and byte count
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state      <= ST_INSTR;
      bit_cnt    <= 5'h0;
      shift      <= 16'h0;
      is_read    <= 1'b0;
      byte_mode  <= 2'h0;
      bytes_left <= 2'h0;
      addr       <= 13'h0;
      tx_byte    <= 8'h00;
    end else if (!frame) begin
      state   <= ST_INSTR;
      bit_cnt <= 5'h0;
    end else if (sclk_rise && state != ST_DONE) begin
      shift <= next_shift;
      if (instr_done) begin
        state      <= ST_DATA;
        bit_cnt    <= 5'h0;
        is_read    <= instr_hi[7];
        byte_mode  <= {instr_hi[6], instr_hi[5]};
        bytes_left <= {instr_hi[6], instr_hi[5]};
        addr       <= instr_addr;
        tx_byte    <= read_reg(instr_addr);
      end else if (byte_done) begin
        bit_cnt <= 5'h0;
        addr    <= step_addr(addr, lsb_first);
        tx_byte <= read_reg(step_addr(addr, lsb_first));
        if (byte_mode != `ASRB_W_STREAM) begin
          if (bytes_left == 2'h0) begin
            state <= ST_DONE;
          end else begin
            bytes_left <= bytes_left - 2'h1;
          end
        end
      end else begin
        bit_cnt <= bit_cnt + 5'h1;
      end
    end
  end

  // Read data leaves on falling sclk, enable held for the read data phase
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
    end else if (!frame || state != ST_DATA || !is_read) begin
      sdio_oe <= 1'b0;
    end else if (sclk_fall) begin
      sdio_oe  <= 1'b1;
      sdio_out <= lsb_first ? tx_byte[bit_cnt[2:0]] : tx_byte[3'h7 - bit_cnt[2:0]];
    end
  end

  // Register writes, soft reset, commit
  // RULE17: defaults on reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lsb_first   <= 1'b0;
      soft_reset  <= 1'b0;
      sh_power    <= `ASRB_RST_POWER_STATE;
      sh_stab     <= `ASRB_RST_STABILIZER;
      sh_pattern  <= `ASRB_RST_PATTERN_SEL;
      sh_input    <= `ASRB_RST_INPUT_PATH;
      act_power   <= `ASRB_RST_POWER_STATE;
      act_stab    <= `ASRB_RST_STABILIZER;
      act_pattern <= `ASRB_RST_PATTERN_SEL;
      act_input   <= `ASRB_RST_INPUT_PATH;
      commit_bit  <= 1'b0;
    end else if (soft_reset) begin
      soft_reset  <= 1'b0;
      lsb_first   <= 1'b0;
      sh_power    <= `ASRB_RST_POWER_STATE;
      sh_stab     <= `ASRB_RST_STABILIZER;
      sh_pattern  <= `ASRB_RST_PATTERN_SEL;
      sh_input    <= `ASRB_RST_INPUT_PATH;
      act_power   <= `ASRB_RST_POWER_STATE;
      act_stab    <= `ASRB_RST_STABILIZER;
      act_pattern <= `ASRB_RST_PATTERN_SEL;
      act_input   <= `ASRB_RST_INPUT_PATH;
      commit_bit  <= 1'b0;
    end else begin
      // RULE3: simultaneous update
      if (commit_bit) begin
        act_power   <= sh_power;
        act_stab    <= sh_stab;
        act_pattern <= sh_pattern;
        act_input   <= sh_input;
      end
      // RULE2: commit set wins
      // RULE4: self clearing
      if (wr_en && addr == `ASRB_ADDR_COMMIT && rx_byte[`ASRB_CM_BIT]) begin
        commit_bit <= 1'b1;
      end else if (commit_bit) begin
        commit_bit <= 1'b0;
      end
      if (wr_en && addr == `ASRB_ADDR_PORT_SETUP) begin
        lsb_first  <= rx_byte[`ASRB_PS_LSB_HI] | rx_byte[`ASRB_PS_LSB_LO];
        soft_reset <= rx_byte[`ASRB_PS_SRST_HI] | rx_byte[`ASRB_PS_SRST_LO];
      end
      // RULE1: shadow only writes
      if (wr_en && addr == `ASRB_ADDR_POWER_STATE) begin
        sh_power <= rx_byte & 8'h27;
      end
      if (wr_en && addr == `ASRB_ADDR_STABILIZER) begin
        sh_stab <= rx_byte & 8'h01;
      end
      if (wr_en && addr == `ASRB_ADDR_PATTERN_SEL) begin
        sh_pattern <= rx_byte & 8'h3f;
      end
      if (wr_en && addr == `ASRB_ADDR_INPUT_PATH) begin
        sh_input <= rx_byte & 8'h06;
      end
    end
  end

  // Function outputs from the active copy
  // RULE7: power state decode
  // RULE8: pin overrides register
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      full_powerdown   <= 1'b0;
      standby          <= 1'b0;
      dcs_enable       <= 1'b1;
      input_disconnect <= 1'b0;
      common_mode_out  <= 1'b0;
    end else begin
      if (pin_sync[1]) begin
        full_powerdown <= ~act_power[`ASRB_PW_PIN_MODE];
        standby        <= act_power[`ASRB_PW_PIN_MODE];
      end else begin
        full_powerdown <= act_power[`ASRB_PW_MODE_MSB:0] == `ASRB_PW_FULL;
        standby        <= act_power[`ASRB_PW_MODE_MSB:0] == `ASRB_PW_STANDBY;
      end
      // RULE9: stabilizer enable
      dcs_enable       <= act_stab[`ASRB_DCS_EN];
      // RULE12: input disconnect
      input_disconnect <= act_input[`ASRB_IP_DISCONNECT];
      common_mode_out  <= act_input[`ASRB_IP_CM_OUT];
    end
  end

  // Test pattern source on the data outputs
  // RULE10: pattern in place of data
  asrb_pattern #(
    .DATA_W (DATA_W)
  ) u_pattern (
    .clock       (clock),
    .rst         (rst),
    .test_mode   (act_pattern[`ASRB_TP_MODE_MSB:0]),
    .hold_long   (act_pattern[`ASRB_TP_HOLD_LONG]),
    .hold_short  (act_pattern[`ASRB_TP_HOLD_SHORT]),
    .conv_data   (conv_data),
    .data_out    (data_out),
    .test_active (test_active)
  );

endmodule // asrb_bank
`default_nettype wire

// [test/asrb_bank_properties.sv]
// Purpose: Port-level properties of the register bank
// Assumes: Bound to asrb_bank, one clock domain
// Notes:   Margins follow the serial sampling depth
`timescale 1ns/10ps
`default_nettype none
module asrb_props #(
  parameter DATA_W = 11
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              csb_n,
  input wire logic              sclk,
  input wire logic              powerdown_pin,
  input wire logic [DATA_W-1:0] conv_data,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              sdio_out,
  input wire logic              sdio_oe,
  input wire logic              test_active,
  input wire logic              full_powerdown,
  input wire logic              standby,
  input wire logic              dcs_enable,
  input wire logic              input_disconnect,
  input wire logic              common_mode_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Active copies leave reset at their defaults
  property p_dflt; $fell(rst) |-> dcs_enable && !test_active && !input_disconnect; endproperty
  a_dflt: assert property (p_dflt) else $error("reset defaults");
  property p_pass; !test_active && !$past(rst) |-> data_out == $past(conv_data); endproperty
  a_pass: assert property (p_pass) else $error("data not passed");
  property p_pin; powerdown_pin [*5] |-> full_powerdown || standby; endproperty
  a_pin: assert property (p_pin) else $error("pin ignored");
  property p_excl; !(full_powerdown && standby); endproperty
  a_excl: assert property (p_excl) else $error("two power states");
  // Stabilizer, input path and test_active outputs hold while the port is idle; power outputs follow the pin
  property p_quiet;
    csb_n [*8] |=> $stable(dcs_enable) && $stable(input_disconnect)
      && $stable(common_mode_out) && $stable(test_active);
  endproperty
  a_quiet: assert property (p_quiet) else $error("active change idle");
  property p_oe_idle; csb_n [*5] |-> !sdio_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive idle");
  property p_oe_rise; $rose(sdio_oe) |-> !csb_n && !$past(csb_n, 3); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive start");
  property p_stand; sdio_oe && $past(sdio_oe) && $changed(sdio_out) |-> !$past(sclk, 2); endproperty
  a_stand: assert property (p_stand) else $error("read bit moved");
  c_pat: cover property (test_active);
  c_oe: cover property ($rose(sdio_oe));
  c_pin: cover property (powerdown_pin && standby);
endmodule // asrb_props
bind asrb_bank asrb_props #(.DATA_W(DATA_W)) i_props (.clock(clock), .rst(rst),
  .csb_n(csb_n), .sclk(sclk), .powerdown_pin(powerdown_pin), .conv_data(conv_data),
  .data_out(data_out), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .test_active(test_active),
  .full_powerdown(full_powerdown), .standby(standby), .dcs_enable(dcs_enable),
  .input_disconnect(input_disconnect), .common_mode_out(common_mode_out));
`default_nettype wire

// [test/asrb_host.sv]
// Purpose: Serial host on the three-wire port
// Assumes: 4 ns clock; serial half period of 10 cycles
// Notes:   Released data line sits at the pull-up level
`timescale 1ns/10ps
`default_nettype none
module asrb_host (
  input  wire logic clock,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  output var logic  csb_n,
  output var logic  sclk,
  output wire logic sdio_in
);
  logic lsb = 1'b0;
  logic drv = 1'b0;
  logic bv  = 1'b0;
  // Shared line, pull-up when nobody drives
  assign sdio_in = sdio_oe ? sdio_out : (drv ? bv : 1'b1);
  initial begin
    csb_n = 1'b1;
    sclk  = 1'b0;
  end
  task half;
    repeat (10) @(negedge clock);
  endtask
  // One bit, line sampled before the rise
  task bitx(input logic b, output logic s);
    bv = b;
    half;
    s = sdio_in;
    sclk = 1'b1;
    half;
    sclk = 1'b0;
  endtask
  task acc(input logic rd, input logic [1:0] w, input logic [12:0] a,
           input logic [15:0] d, output logic [15:0] q);
    logic [15:0] ins;
    logic        s;
    int          n;
    ins = {rd, w, a};
    n = 8 * (w + 1);
    q = 16'h0;
    @(negedge clock);
    csb_n = 1'b0;
    drv = 1'b1;
    for (int i = 0; i < 16; i++) bitx(lsb ? ins[i] : ins[15 - i], s);
    drv = !rd;
    for (int i = 0; i < n; i++) begin
      bitx(lsb ? d[i] : d[n - 1 - i], s);
      q = lsb ? q | (16'(s) << i) : {q[14:0], s};
    end
    half;
    csb_n = 1'b1;
    drv = 1'b0;
    half;
  endtask
endmodule // asrb_host
`default_nettype wire

// [test/testbench.sv]
// Purpose: Self-checking bench for the register bank
// Assumes: Host model drives the serial port
// Notes:   Serial clock runs only inside frames
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] PID = 8'h96; // Arbitrary value
  localparam logic [1:0] SG  = 2'h2;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        pd = 1'b0;
  logic [10:0] conv = 11'h123;
  logic        csb_n, sclk, sdio_in, sdio_out, sdio_oe;
  logic        tact, fpd, stby, dcs, dis, cm;
  logic [10:0] dout, a1;
  logic [15:0] q;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [12:0] ra [6] = '{13'h0, 13'h8, 13'h9, 13'hd, 13'hf, 13'hff};
  logic [7:0]  rv [6] = '{8'h18, 8'h0, 8'h1, 8'h0, 8'h0, 8'h0};
  logic [7:0]  tc [8] = '{8'h1, 8'h2, 8'h3, 8'h4, 8'h7, 8'h35, 8'h36, 8'h0};
  logic [10:0] te [8] = '{11'h400, 11'h7ff, 11'h0, 11'h555, 11'h7ff, 11'h7ff, 11'h7ff, 11'h123};
  logic [7:0]  ta = 8'b00011000;
  asrb_bank #(.PART_ID(PID), .SPEED_GRADE(SG), .DATA_W(11)) i_dut (
    .clock(clock), .rst(rst), .csb_n(csb_n), .sclk(sclk), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .powerdown_pin(pd), .conv_data(conv),
    .data_out(dout), .test_active(tact), .full_powerdown(fpd), .standby(stby),
    .dcs_enable(dcs), .input_disconnect(dis), .common_mode_out(cm));
  asrb_host i_host (.clock(clock), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .csb_n(csb_n), .sclk(sclk), .sdio_in(sdio_in));
  initial forever #2 clock = ~clock;
  // Cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [12:0] a, input logic [7:0] d);
    i_host.acc(1'b0, 2'h0, a, {8'h0, d}, q);
  endtask
  task rd(input logic [12:0] a, input logic [7:0] e);
    i_host.acc(1'b1, 2'h0, a, 16'h0, q);
    chk("read", {8'h0, e}, q);
  endtask
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(13'h1, 8'hff);
    rd(13'h1, PID);
    rd(13'h2, {3'h0, SG, 3'h0});
    rd(13'h5, 8'h0);
    i_host.acc(1'b0, 2'h1, 13'h9, 16'h0001, q);
    wr(13'hf, 8'h06);
    chk("held", 4'h4, {fpd, dcs, dis, cm});
    rd(13'h8, 8'h01);
    wr(13'hff, 8'h01);
    chk("commit", 4'hb, {fpd, dcs, dis, cm});
    rd(13'hff, 8'h0);
    for (int c = 0; c < 4; c++) begin
      wr(13'h8, 8'(c));
      wr(13'hff, 8'h01);
      chk("power", {c == 1, c == 2}, {fpd, stby});
    end
    pd = 1'b1;
    repeat (5) @(negedge clock);
    chk("pin", 2'h2, {fpd, stby});
    wr(13'h8, 8'h20);
    wr(13'hff, 8'h01);
    chk("pin", 2'h1, {fpd, stby});
    pd = 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(13'hd, tc[i]);
      wr(13'hff, 8'h01);
      a1 = dout;
      @(negedge clock);
      chk("pattern", te[i], (ta[i] && a1 !== te[i]) ? a1 ^ 11'h7ff : a1);
      chk("next", ta[i] ? a1 ^ 11'h7ff : a1, dout);
      chk("active", tc[i] != 8'h0, tact);
    end
    // Moving converter words pass with one clock of delay
    for (int i = 0; i < 3; i++) begin
      conv = 11'h2c0 + 11'(i);
      @(negedge clock);
      chk("pass", conv, dout);
    end
    wr(13'h0, 8'h5a);
    i_host.lsb = 1'b1;
    rd(13'h0, 8'h5a);
    i_host.acc(1'b0, 2'h1, 13'h8, 16'h0102, q);
    rd(13'h8, 8'h02);
    rd(13'h9, 8'h01);
    wr(13'hff, 8'h01);
    chk("lsb", 2'h1, {fpd, stby});
    wr(13'h0, 8'h3c);
    i_host.lsb = 1'b0;
    rd(13'h0, 8'h18);
    chk("soft", 4'h2, {fpd, stby, dcs, dis});
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
